// ### src/bcm_pkg.sv
// package for the battery charger mode controller
package bcm_pkg;

	// one-hot charger modes
	typedef enum logic [4:0] {
		BCM_OFF     = 5'h01,
		BCM_TRICKLE = 5'h02,
		BCM_FAST    = 5'h04,
		BCM_STANDBY = 5'h08,
		BCM_ERROR   = 5'h10
	} bcm_mode_e;

	// register byte offsets
	localparam logic [3:0] BCM_REG_CTRL   = 4'h0;
	localparam logic [3:0] BCM_REG_ISET   = 4'h4;
	localparam logic [3:0] BCM_REG_STATUS = 4'h8;
	localparam logic [3:0] BCM_REG_IRQ    = 4'hc;

	// mask register takes the address slot after irq status
	localparam logic [5:0] BCM_REG_MASK   = 6'h10;

	// control field positions
	localparam int BCM_CTRL_EN_BIT  = 0;
	localparam int BCM_CTRL_SRC_BIT = 1;

	// current setting limits in ma and reset values
	localparam logic [7:0] BCM_I_MIN      = 8'h0a;
	localparam logic [7:0] BCM_I_MAX      = 8'hc8;
	localparam logic [7:0] BCM_ISET_RST   = 8'h64;
	localparam logic [7:0] BCM_TRIM_RST   = 8'h00;
	localparam logic [4:0] BCM_MASK_RST   = 5'h00;

	// divisor for the tenth-of-fast current
	localparam logic [7:0] BCM_TENTH_DIV  = 8'h0a;

endpackage

// ### src/bcm_sync.sv
// three flop synchroniser with agreement filter
module bcm_sync
	import bcm_pkg::*;
#(
	parameter int W = 6
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// three stage shift toward the logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= async_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// per bit: take a new level only once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync_o[g] <= 1'b0;
				end else if (s2[g] == s3[g]) begin
					sync_o[g] <= s3[g];
				end
			end
		end
	endgenerate

endmodule

// ### src/bcm_ctrl.sv
// battery charger mode controller with wishbone registers
module bcm_ctrl
	import bcm_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [5:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// stored settings loaded by firmware
	input  wire logic [7:0]  persistent_setting_i,
	input  wire logic [7:0]  trim_i,
	// analog comparator results, asynchronous
	input  wire logic        vbat_present_i,
	input  wire logic        fast_threshold_up_i,
	input  wire logic        fast_threshold_dn_i,
	input  wire logic        float_voltage_i,
	input  wire logic        recharge_hysteresis_i,
	input  wire logic        charger_input_level_i,
	input  wire logic        termination_current_i,
	// charger drive
	output logic      [4:0]  mode_o,
	output logic      [7:0]  current_target_o,
	output logic             cc_en_o,
	output logic             cv_en_o,
	output logic             irq_o
);

	// number of comparator levels that cross into the clock domain
	localparam int NCMP = 7;

	logic [NCMP-1:0] cmp_raw;
	logic [NCMP-1:0] cmp;
	logic            vbat_ok;
	logic            above_up;
	logic            above_dn;
	logic            at_float;
	logic            below_rech;
	logic            input_low;
	logic            below_term;

	logic            enable;
	logic            use_reg;
	logic [7:0]      iset_reg;
	logic [7:0]      trim_reg;
	logic [4:0]      irq_stat;
	logic [4:0]      irq_mask;

	bcm_mode_e       mode;
	bcm_mode_e       next_mode;
	logic            fast_side;
	logic            next_fast_side;
	logic            mode_chg;

	logic [7:0]      iset_sel;
	logic [7:0]      iset_clip;
	logic [8:0]      iset_trim;
	logic [7:0]      fast_current_setting;
	logic [7:0]      itrickle;
	logic [7:0]      next_target;

	logic            wb_req;
	logic            wb_wr;
	logic            wb_rd;
	logic [31:0]     next_dat;

	// comparator inputs cross into the clock domain
	assign cmp_raw = {termination_current_i, charger_input_level_i,
		recharge_hysteresis_i, float_voltage_i, fast_threshold_dn_i,
		fast_threshold_up_i, vbat_present_i};

	bcm_sync #(
		.W       (NCMP)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (cmp_raw),
		.sync_o  (cmp)
	);

	// named comparator levels
	assign vbat_ok    = cmp[0];
	assign above_up   = cmp[1];
	assign above_dn   = cmp[2];
	assign at_float   = cmp[3];
	assign below_rech = cmp[4];
	assign input_low  = cmp[5];
	assign below_term = cmp[6];

	// wishbone decode, one cycle answer
	// a request is taken on the edge where cyc and stb are high and ack is
	// low; ack then stands for exactly one cycle, and masking the request
	// with ack keeps a held strobe from being taken a second time
	assign wb_req = cyc_i & stb_i & ~ack_o;
	assign wb_wr  = wb_req & we_i;
	assign wb_rd  = wb_req & ~we_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= wb_req;
		end
	end

	// control register: enable and current source select
	// enable comes only from supervising code, so the charger stays off
	// after reset until software asks for it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable  <= 1'b0;
			use_reg <= 1'b0;
		end else if (wb_wr && adr_i == {2'b00, BCM_REG_CTRL} && sel_i[0]) begin
			enable  <= dat_i[BCM_CTRL_EN_BIT];
			use_reg <= dat_i[BCM_CTRL_SRC_BIT];
		end
	end

	// current setting and calibration trim
	// the trim is a signed byte, written by charger firmware; the setting
	// byte is only used when the control source bit selects it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			iset_reg <= BCM_ISET_RST;
			trim_reg <= BCM_TRIM_RST;
		end else if (wb_wr && adr_i == {2'b00, BCM_REG_ISET}) begin
			if (sel_i[0]) begin
				iset_reg <= dat_i[7:0];
			end
			if (sel_i[1]) begin
				trim_reg <= dat_i[15:8];
			end
		end
	end

	// interrupt mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask <= BCM_MASK_RST;
		end else if (wb_wr && adr_i == BCM_REG_MASK && sel_i[0]) begin
			irq_mask <= dat_i[4:0];
		end
	end

	// fast current: pick source, clamp range, add signed trim
	// the clamp keeps an out-of-range setting inside the legal band, and
	// the trimmed sum saturates at both ends so a large negative trim
	// cannot wrap round to a high current
	always_comb begin
		iset_sel = use_reg ? iset_reg : persistent_setting_i;
		if (iset_sel < BCM_I_MIN) begin
			iset_clip = BCM_I_MIN;
		end else if (iset_sel > BCM_I_MAX) begin
			iset_clip = BCM_I_MAX;
		end else begin
			iset_clip = iset_sel;
		end
		iset_trim = {1'b0, iset_clip} + {trim_reg[7], trim_reg};
		if (trim_reg[7] && !iset_trim[8]) begin
			fast_current_setting = iset_trim[7:0]; // negative trim without underflow
		end else if (trim_reg[7]) begin
			fast_current_setting = 8'h00;
		end else if (iset_trim[8]) begin
			fast_current_setting = 8'hff;
		end else begin
			fast_current_setting = iset_trim[7:0];
		end
		itrickle = fast_current_setting / BCM_TENTH_DIV;
	end

	// hysteretic fast threshold: rise on upper, fall on lower
	// between the two levels the last side is kept, so a battery sitting
	// near the threshold cannot make trickle and fast alternate
	always_comb begin
		next_fast_side = fast_side;
		if (above_up) begin
			next_fast_side = 1'b1;
		end else if (!above_dn) begin
			next_fast_side = 1'b0;
		end
	end

	// mode selection, off first, then error, then charging choices
	// the choice is remade on every clock from the synchronised levels,
	// so a mode change never waits for anything but the synchroniser
	always_comb begin
		next_mode = mode;
		if (!enable) begin
			next_mode = BCM_OFF;
		end else if (input_low) begin
			next_mode = BCM_ERROR;
		end else begin
			case (mode)
				BCM_OFF, BCM_ERROR: begin
					if (!vbat_ok) begin
						next_mode = BCM_OFF;
					end else if (next_fast_side) begin
						next_mode = BCM_FAST;
					end else begin
						next_mode = BCM_TRICKLE;
					end
				end
				BCM_TRICKLE: begin
					if (!vbat_ok) begin
						next_mode = BCM_OFF;
					end else if (next_fast_side) begin
						next_mode = BCM_FAST;
					end
				end
				BCM_FAST: begin
					if (!vbat_ok) begin
						next_mode = BCM_OFF;
					end else if (!next_fast_side) begin
						next_mode = BCM_TRICKLE;
					end else if (at_float && below_term) begin
						next_mode = BCM_STANDBY;
					end
				end
				BCM_STANDBY: begin
					if (!vbat_ok) begin
						next_mode = BCM_OFF;
					end else if (below_rech) begin
						next_mode = BCM_FAST;
					end
				end
				default: begin
					next_mode = BCM_OFF;
				end
			endcase
		end
	end

	// state update every clock
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode      <= BCM_OFF;
			fast_side <= 1'b0;
		end else begin
			mode      <= next_mode;
			fast_side <= next_fast_side;
		end
	end

	// current target per mode
	// standby, error and off all ask for no current at all
	always_comb begin
		case (next_mode)
			BCM_TRICKLE: next_target = itrickle;
			BCM_FAST:    next_target = fast_current_setting;
			default:     next_target = 8'h00;
		endcase
	end

	// charger drive outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_o           <= BCM_OFF;
			current_target_o <= 8'h00;
			cc_en_o          <= 1'b0;
			cv_en_o          <= 1'b0;
		end else begin
			mode_o           <= next_mode;
			current_target_o <= next_target;
			cc_en_o          <= (next_mode == BCM_TRICKLE) ||
				(next_mode == BCM_FAST && !at_float);
			cv_en_o          <= (next_mode == BCM_FAST) && at_float;
		end
	end

	// sticky mode-entry events, read clears, set wins
	// each status bit matches the one-hot code of the mode entered
	assign mode_chg = (next_mode != mode);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat <= 5'h00;
		end else begin
			irq_stat <= (irq_stat &
				~((wb_rd && adr_i == {2'b00, BCM_REG_IRQ}) ? 5'h1f : 5'h00)) |
				(mode_chg ? next_mode : 5'h00);
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// read mux, unmapped reads zero
	// status: mode low, drive enables, effective fast current, comparators
	always_comb begin
		next_dat = 32'h0000_0000;
		case (adr_i)
			{2'b00, BCM_REG_CTRL}:   next_dat = {30'h0, use_reg, enable};
			{2'b00, BCM_REG_ISET}:   next_dat = {16'h0, trim_reg, iset_reg};
			{2'b00, BCM_REG_STATUS}: next_dat = {9'h0, cmp, fast_current_setting, 1'b0,
				cv_en_o, cc_en_o, mode};
			{2'b00, BCM_REG_IRQ}:    next_dat = {27'h0, irq_stat};
			BCM_REG_MASK:            next_dat = {27'h0, irq_mask};
			default:                 next_dat = 32'h0000_0000;
		endcase
	end

	// read data is captured on the taking edge and holds until next read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (wb_rd) begin
			dat_o <= next_dat;
		end
	end

endmodule

// ### bench/bcm_batt_model.sv
// battery cell and charger supply model giving comparator levels
module bcm_batt_model
#(
	parameter int UP_MV     = 3100,
	parameter int DN_MV     = 2900,
	parameter int FLOAT_MV  = 4200,
	parameter int RECH_MV   = 4050,
	parameter int MARGIN_MV = 50
) (
	input  wire logic [15:0] vbat_mv_i,
	input  wire logic [15:0] sup_mv_i,
	input  wire logic        term_i,
	output logic             present_o,
	output logic             up_o,
	output logic             dn_o,
	output logic             flt_o,
	output logic             rech_o,
	output logic             low_o,
	output logic             trm_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// two thresholds around the fast level give the hysteresis band
	assign present_o = vbat_mv_i != 16'h0000;
	assign up_o      = vbat_mv_i > UP_MV;
	assign dn_o      = vbat_mv_i > DN_MV;
	assign flt_o     = vbat_mv_i >= FLOAT_MV;
	assign rech_o    = vbat_mv_i < RECH_MV;
	assign low_o     = vbat_mv_i + MARGIN_MV > sup_mv_i;
	assign trm_o     = term_i;
endmodule

// ### bench/bcm_ctrl_sva.sv
// port assertions for the charger mode controller
module bcm_ctrl_sva
	import bcm_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic [31:0] dat_o,
	input  wire logic        ack_o,
	input  wire logic        vbat_present_i,
	input  wire logic        charger_input_level_i,
	input  wire logic [4:0]  mode_o,
	input  wire logic [7:0]  current_target_o,
	input  wire logic        cc_en_o,
	input  wire logic        cv_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_mode_onehot: assert property ($onehot(mode_o))
		else $error("mode not one-hot");
	a_reset_off: assert property ($past(rst_i) |-> mode_o == BCM_OFF)
		else $error("not off after reset");
	a_absent_off: assert property (!vbat_present_i [*7] |-> mode_o == BCM_OFF)
		else $error("no battery but not off");
	a_low_input_err: assert property ((vbat_present_i && charger_input_level_i) [*7]
		|-> mode_o inside {BCM_OFF, BCM_ERROR})
		else $error("low input without error mode");
	a_off_idle: assert property (mode_o == BCM_OFF
		|-> !cc_en_o && !cv_en_o && current_target_o == 8'h00)
		else $error("drive active while off");
	a_stop_idle: assert property (mode_o inside {BCM_ERROR, BCM_STANDBY}
		|-> !cc_en_o && !cv_en_o)
		else $error("charging in error or standby");
	a_trickle_tenth: assert property (mode_o == BCM_TRICKLE
		|-> cc_en_o && current_target_o <= 8'h19)
		else $error("trickle current too high");
	a_fast_drive: assert property (mode_o == BCM_FAST |-> cc_en_o != cv_en_o)
		else $error("fast mode drive wrong");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_dat_hold: assert property (!ack_o |-> $stable(dat_o))
		else $error("read data changed without ack");
endmodule

bind bcm_ctrl bcm_ctrl_sva chk_u (
	.clk_i                 (clk_i),
	.rst_i                 (rst_i),
	.cyc_i                 (cyc_i),
	.stb_i                 (stb_i),
	.dat_o                 (dat_o),
	.ack_o                 (ack_o),
	.vbat_present_i        (vbat_present_i),
	.charger_input_level_i (charger_input_level_i),
	.mode_o                (mode_o),
	.current_target_o      (current_target_o),
	.cc_en_o               (cc_en_o),
	.cv_en_o               (cv_en_o)
);

// ### bench/tb_top.sv
// self-checking bench for the charger mode controller
module tb_top
	import bcm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [15:0] mv;
		logic [15:0] sup;
		logic        term;
		bcm_mode_e   mode;
		logic [7:0]  tgt;
	} bcm_row_s;
	localparam logic [15:0] S = 16'h1388;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i, stb_i, we_i, term, ack_o, irq_o, cc_en_o, cv_en_o;
	logic        pres, up, dn, flt, rech, low, trm;
	logic [5:0]  adr_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [15:0] mv, sup;
	logic [4:0]  mode_o;
	logic [7:0]  current_target_o;
	int          n_fail = 0, n_compared = 0, cycles = 0;
	logic [31:0] iv [4] = '{32'h0000_0005, 32'h0000_00fa, 32'h0000_ff64,
		32'h0000_0164};
	logic [7:0]  it [4] = '{8'h0a, 8'hc8, 8'h63, 8'h65};
	bcm_row_s    rows [13] = '{
		'{16'h03e8, S, 1'h0, BCM_TRICKLE, 8'h0a},
		'{16'h0c80, S, 1'h0, BCM_FAST, 8'h64},
		'{16'h0bb8, S, 1'h0, BCM_FAST, 8'h64},
		'{16'h0af0, S, 1'h0, BCM_TRICKLE, 8'h0a},
		'{16'h0bb8, S, 1'h0, BCM_TRICKLE, 8'h0a},
		'{16'h0c80, S, 1'h0, BCM_FAST, 8'h64},
		'{16'h1068, S, 1'h0, BCM_FAST, 8'h64},
		'{16'h1068, S, 1'h1, BCM_STANDBY, 8'h00},
		'{16'h1004, S, 1'h0, BCM_STANDBY, 8'h00},
		'{16'h0fa0, S, 1'h0, BCM_FAST, 8'h64},
		'{16'h0fa0, 16'h0bb8, 1'h0, BCM_ERROR, 8'h00},
		'{16'h0fa0, S, 1'h0, BCM_FAST, 8'h64},
		'{16'h0000, S, 1'h0, BCM_OFF, 8'h00}};

	bcm_batt_model batt_u (.vbat_mv_i(mv), .sup_mv_i(sup), .term_i(term),
		.present_o(pres), .up_o(up), .dn_o(dn), .flt_o(flt), .rech_o(rech),
		.low_o(low), .trm_o(trm));
	bcm_ctrl dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
		.sel_i(4'hf), .dat_i, .dat_o, .ack_o, .persistent_setting_i(8'h64),
		.trim_i(8'h00), .vbat_present_i(pres), .fast_threshold_up_i(up),
		.fast_threshold_dn_i(dn), .float_voltage_i(flt),
		.recharge_hysteresis_i(rech), .charger_input_level_i(low),
		.termination_current_i(trm), .mode_o, .current_target_o, .cc_en_o,
		.cv_en_o, .irq_o);

	// free-running clock, 50 ns period
	initial begin
		forever #25 clk_i = ~clk_i;
	end

	task automatic report_and_stop();
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	// hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// main sequence
	initial begin
		{cyc_i, stb_i, we_i, term} = 4'h0;
		adr_i = 6'h00;
		dat_i = 32'h0;
		mv = 16'h0000;
		sup = S;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(mode_o, BCM_OFF);
		chk({irq_o, current_target_o}, 9'h000);
		wb(1'b1, BCM_REG_CTRL, 32'h1);
		for (int i = 0; i < 13; i++) begin
			mv <= rows[i].mv;
			sup <= rows[i].sup;
			term <= rows[i].term;
			repeat (8) @(posedge clk_i);
			chk(mode_o, rows[i].mode);
			if (rows[i].tgt !== 8'hff) chk(current_target_o, rows[i].tgt);
			$display("row %0d done", i);
		end
		wb(1'b1, BCM_REG_MASK, 32'h1f);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		wb(1'b0, BCM_REG_IRQ, 32'h0);
		chk(rd, 32'h1f);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(1'b1, BCM_REG_MASK, 32'h0);
		mv <= 16'h03e8;
		repeat (8) @(posedge clk_i);
		chk(irq_o, 1'b0);
		wb(1'b1, BCM_REG_MASK, 32'h1f);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 1'b1);
		$display("irq test done");
		mv <= 16'h0c80;
		wb(1'b1, BCM_REG_CTRL, 32'h3);
		for (int k = 0; k < 4; k++) begin
			wb(1'b1, BCM_REG_ISET, iv[k]);
			repeat (8) @(posedge clk_i);
			chk(current_target_o, it[k]);
		end
		wb(1'b0, BCM_REG_STATUS, 32'h0);
		chk({rd[15:8], 3'h0, rd[4:0]}, 16'h6504);
		wb(1'b1, 6'h14, 32'hffff_ffff);
		wb(1'b0, 6'h14, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, BCM_REG_CTRL, 32'h0);
		repeat (8) @(posedge clk_i);
		chk(mode_o, BCM_OFF);
		chk(current_target_o, 8'h00);
		$display("register test done");
		report_and_stop();
	end
endmodule
